// file: hdl/gpio_port_pkg.sv
// shared types and constants of the port expander core
package gpio_port_pkg;
    localparam int         NUM_PORTS        = 9;
    localparam logic [7:0] PORT_FIRST_ADDR  = 8'h01;
    localparam logic [7:0] PORT_LAST_ADDR   = 8'h09;
    localparam logic [7:0] LOCK_LOW_ADDR    = 8'h72;
    localparam logic [7:0] LOCK_HIGH_ADDR   = 8'h73;
    localparam int         DIR_BIT          = 7;
    localparam int         IRQ_EN_BIT       = 5;
    localparam int         DEBOUNCE_EN_BIT  = 2;
    localparam int         FLAG_BIT         = 1;
    localparam int         LEVEL_BIT        = 0;
    localparam int         LOCK_LOW_LSB     = 3;
    localparam int         LOCK_CFG_BIT     = 1;
    localparam int         LOCK_HIGH_PORTS  = 4;
    localparam logic [7:0] PORT_POR         = 8'h80;
    localparam int         CLK_MHZ          = 250;
    localparam int         DEBOUNCE_MS      = 31;
    localparam int         DEBOUNCE_CYCLES  = DEBOUNCE_MS * CLK_MHZ * 1000;

    // register access request from the serial interface engine
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // output settings of one port as seen by the waveform logic
    typedef struct packed {
        logic       is_input;
        logic       push_pull;
        logic       blink_sel;
        logic [4:0] duty;
    } port_cfg_t;
endpackage : gpio_port_pkg

// file: hdl/gpio_port_core.sv
// per-port control, lock, debounce, change detection and interrupt core
`timescale 1ns/1ps

module gpio_port_core
    import gpio_port_pkg::*;
#(
    parameter int DEBOUNCE_TICKS = DEBOUNCE_CYCLES
)(
    input  wire logic                      CLK,
    input  wire logic                      RESET_N,
    input  wire logic                      HW_RESET_N,
    input  wire reg_req_t                  REG_REQ,
    input  wire logic                      BUS_READ_ACTIVE,
    input  wire logic                      BUS_STOP,
    input  wire logic                      CFG_RESTORE_DEFAULTS,
    input  wire logic                      CFG_CLEAR_TIMERS,
    input  wire logic [NUM_PORTS-1:0]      PORT_IN,
    input  wire logic [NUM_PORTS-1:0]      LOGIC_ARRAY_OUT,
    output logic      [7:0]                REG_RDATA,
    output port_cfg_t [NUM_PORTS-1:0]      PORT_CFG,
    output logic                           CONFIG_LOCK,
    output logic                           INT_N,
    output logic                           INT_STATUS_N,
    output logic                           TRANSITION_N,
    output logic                           BUS_ABORT,
    output logic                           TIMER_CLEAR
);
    typedef struct packed {
        logic [NUM_PORTS-1:0][7:0] ctrl;
        logic [NUM_PORTS-1:0]      lock_port;
        logic                      lock_cfg;
        logic [NUM_PORTS-1:0]      sync1;
        logic [NUM_PORTS-1:0]      sync2;
        logic [NUM_PORTS-1:0]      sample;
        logic [NUM_PORTS-1:0]      deb;
        logic [NUM_PORTS-1:0]      snap;
        logic [NUM_PORTS-1:0]      flag;
        logic [31:0]               cnt;
        logic                      intr;
        logic                      pend;
        logic [7:0]                rdata;
        logic                      abort;
        logic                      tclr;
        logic                      trans_n;
    } state_t;

    localparam state_t STATE_POR = '{ctrl: {NUM_PORTS{PORT_POR}}, trans_n: 1'b1, default: '0};

    state_t               state;
    state_t               next_state;
    logic   [1:0]         hw_sync;
    logic                 hw_active;
    logic                 tick;
    logic                 is_port;
    logic   [3:0]         idx;
    logic   [NUM_PORTS-1:0] level;
    logic   [NUM_PORTS-1:0] monitored;
    logic   [NUM_PORTS-1:0] rd_port;
    logic   [NUM_PORTS-1:0] event_irq;
    logic   [NUM_PORTS-1:0] live_irq;

    // hardware reset: asynchronous assert, synchronous release
    always_ff @(posedge CLK or negedge HW_RESET_N)
    begin
        if (!HW_RESET_N)
            hw_sync <= 2'b00;
        else
            hw_sync <= {hw_sync[0], 1'b1};
    end

    assign hw_active = !hw_sync[1];

    always_comb
    begin
        next_state = state;
        next_state.sync1 = PORT_IN;
        next_state.sync2 = state.sync1;
        tick = (state.cnt == 32'(DEBOUNCE_TICKS - 1));
        next_state.cnt = tick ? 32'h0000_0000 : state.cnt + 32'h0000_0001;
        is_port = !hw_active && (REG_REQ.addr >= PORT_FIRST_ADDR)
                  && (REG_REQ.addr <= PORT_LAST_ADDR);
        idx = 4'(REG_REQ.addr - PORT_FIRST_ADDR);
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            // inputs and logic array outputs are watched; plain outputs never
            monitored[p] = state.ctrl[p][DIR_BIT] || LOGIC_ARRAY_OUT[p];
            level[p] = state.ctrl[p][DEBOUNCE_EN_BIT] ? state.deb[p] : state.sync2[p];
            if (tick)
            begin
                next_state.sample[p] = state.sync2[p];
                if (state.sync2[p] == state.sample[p])
                    next_state.deb[p] = state.sync2[p];
            end
            rd_port[p] = is_port && REG_REQ.rd && (idx == 4'(p));
            // flag sets on any change, enabled or not
            if (monitored[p] && (level[p] != state.snap[p]))
                next_state.flag[p] = 1'b1;
            // read snapshots the level and clears the flag in the same cycle
            if (rd_port[p])
            begin
                next_state.snap[p] = level[p];
                next_state.flag[p] = 1'b0;
            end
            event_irq[p] = monitored[p] && (level[p] != state.snap[p]) && !state.flag[p]
                           && !rd_port[p] && state.ctrl[p][IRQ_EN_BIT];
            live_irq[p] = state.flag[p] && monitored[p] && state.ctrl[p][IRQ_EN_BIT];
            // locked port keeps every writable bit, input or output
            if (is_port && REG_REQ.wr && (idx == 4'(p)) && !state.lock_port[p])
                next_state.ctrl[p] = REG_REQ.wdata;
        end
        // lock bits accumulate ones only until a hardware reset with restore defaults clears them
        if (!hw_active && REG_REQ.wr && (REG_REQ.addr == LOCK_LOW_ADDR))
        begin
            next_state.lock_port[4:0] = state.lock_port[4:0]
                                        | REG_REQ.wdata[7:LOCK_LOW_LSB];
            next_state.lock_cfg = state.lock_cfg | REG_REQ.wdata[LOCK_CFG_BIT];
        end
        if (!hw_active && REG_REQ.wr && (REG_REQ.addr == LOCK_HIGH_ADDR))
            next_state.lock_port[NUM_PORTS-1:5] = state.lock_port[NUM_PORTS-1:5]
                                      | REG_REQ.wdata[LOCK_HIGH_PORTS-1:0];
        // read data
        if (!hw_active && REG_REQ.rd)
        begin
            if (is_port)
            begin
                if (state.ctrl[idx][DIR_BIT])
                    next_state.rdata = {state.ctrl[idx][7:2], state.flag[idx], level[idx]};
                else
                    next_state.rdata = state.ctrl[idx];
            end
            else if (REG_REQ.addr == LOCK_LOW_ADDR)
                next_state.rdata = {state.lock_port[4:0], 1'b0, state.lock_cfg, 1'b0};
            else if (REG_REQ.addr == LOCK_HIGH_ADDR)
                next_state.rdata = {4'h0, state.lock_port[NUM_PORTS-1:5]};
            else
                next_state.rdata = 8'h00;
        end
        // interrupt: released by any port read; new events win over the release unless a bus read is active, then they only set pend
        if (|rd_port)
            next_state.intr = 1'b0;
        if (|event_irq)
        begin
            if (BUS_READ_ACTIVE)
                next_state.pend = 1'b1;
            else
                next_state.intr = 1'b1;
        end
        if (BUS_STOP && !BUS_READ_ACTIVE)
        begin
            next_state.pend = 1'b0;
            if (state.pend && (|live_irq))
                next_state.intr = 1'b1;
        end
        // hardware reset effects; the interrupt state is left alone
        if (hw_active && CFG_RESTORE_DEFAULTS)
        begin
            next_state.ctrl = STATE_POR.ctrl;
            next_state.lock_port = '0;
            next_state.lock_cfg = 1'b0;
        end
        next_state.abort = hw_active;
        next_state.tclr = hw_active && CFG_CLEAR_TIMERS;
        next_state.trans_n = ~|next_state.flag;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            state <= STATE_POR;
        else
            state <= next_state;
    end

    // outputs straight from the state register
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
            PORT_CFG[p] = port_cfg_t'(state.ctrl[p]);
    end

    assign REG_RDATA    = state.rdata;
    assign CONFIG_LOCK  = state.lock_cfg;
    assign INT_N        = !state.intr;
    assign INT_STATUS_N = !state.intr;
    assign TRANSITION_N = state.trans_n;
    assign BUS_ABORT    = state.abort;
    assign TIMER_CLEAR  = state.tclr;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_lock_sticky;
        !(hw_active && CFG_RESTORE_DEFAULTS)
        |=> ((state.lock_port & $past(state.lock_port)) == $past(state.lock_port));
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit dropped");

    property p_locked_write;
        (REG_REQ.wr && (REG_REQ.addr == PORT_FIRST_ADDR) && state.lock_port[0]
         && !hw_active) |=> $stable(state.ctrl[0]);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked port changed");

    property p_write_takes;
        (REG_REQ.wr && (REG_REQ.addr == PORT_FIRST_ADDR) && !state.lock_port[0]
         && !hw_active) |=> (state.ctrl[0] == $past(REG_REQ.wdata));
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("port write lost");

    property p_change_sets_flag;
        (monitored[0] && (level[0] != state.snap[0]) && !rd_port[0]) |=> state.flag[0];
    endproperty
    a_change_sets_flag: assert property (p_change_sets_flag) else $error("change missed");

    property p_read_clears;
        rd_port[0] |=> (!state.flag[0] && (state.snap[0] == $past(level[0])));
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_output_quiet;
        (!state.ctrl[0][DIR_BIT] && !LOGIC_ARRAY_OUT[0] && !state.flag[0]) |=> !state.flag[0];
    endproperty
    a_output_quiet: assert property (p_output_quiet) else $error("output flagged");

    property p_no_int_in_read;
        (BUS_READ_ACTIVE && !state.intr) |=> !state.intr;
    endproperty
    a_no_int_in_read: assert property (p_no_int_in_read) else $error("int during read");

    property p_int_release;
        (|rd_port && !(|event_irq) && !(BUS_STOP && state.pend)) |=> INT_N;
    endproperty
    a_int_release: assert property (p_int_release) else $error("int not released");

    property p_int_match;
        INT_N == INT_STATUS_N;
    endproperty
    a_int_match: assert property (p_int_match) else $error("int pin and bit differ");

    property p_global_flag;
        ##1 (TRANSITION_N == !(|state.flag));
    endproperty
    a_global_flag: assert property (p_global_flag) else $error("global flag wrong");

    property p_hw_keeps_int;
        (hw_active && state.intr) |=> state.intr;
    endproperty
    a_hw_keeps_int: assert property (p_hw_keeps_int) else $error("reset cleared int");

    property p_hw_abort;
        hw_active |=> (BUS_ABORT && (state.rdata == $past(state.rdata)));
    endproperty
    a_hw_abort: assert property (p_hw_abort) else $error("bus not aborted");

    property p_restore;
        (hw_active && CFG_RESTORE_DEFAULTS) |=> ((state.lock_port == '0) && !CONFIG_LOCK);
    endproperty
    a_restore: assert property (p_restore) else $error("locks not cleared");

    property p_debounce_hold;
        (tick && (state.sync2[0] != state.sample[0])) |=> $stable(state.deb[0]);
    endproperty
    a_debounce_hold: assert property (p_debounce_hold) else $error("debounce too early");

    property p_la_monitored;
        (!state.ctrl[2][DIR_BIT] && LOGIC_ARRAY_OUT[2] && (level[2] != state.snap[2])
         && !rd_port[2]) |=> state.flag[2];
    endproperty
    a_la_monitored: assert property (p_la_monitored) else $error("array output missed");

    property p_read_input;
        (is_port && REG_REQ.rd && state.ctrl[idx][DIR_BIT])
        |=> (REG_RDATA[1:0] == $past({state.flag[idx], level[idx]}));
    endproperty
    a_read_input: assert property (p_read_input) else $error("input status wrong");

    property p_read_output;
        (is_port && REG_REQ.rd && !state.ctrl[idx][DIR_BIT])
        |=> (REG_RDATA == $past(state.ctrl[idx]));
    endproperty
    a_read_output: assert property (p_read_output) else $error("output readback wrong");

    property p_debounce_update;
        (tick && (state.sync2[3] == state.sample[3])) |=> (state.deb[3] == $past(state.sync2[3]));
    endproperty
    a_debounce_update: assert property (p_debounce_update) else $error("debounce stuck");

    property p_int_pend;
        (state.pend && BUS_STOP && !BUS_READ_ACTIVE && (|live_irq)) |=> !INT_N;
    endproperty
    a_int_pend: assert property (p_int_pend) else $error("deferred int lost");

    property p_timer_clear;
        (hw_active && CFG_CLEAR_TIMERS) |=> TIMER_CLEAR;
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("timers not cleared");

    property p_timer_quiet;
        !hw_active |=> !TIMER_CLEAR;
    endproperty
    a_timer_quiet: assert property (p_timer_quiet) else $error("timer clear spurious");

    property p_sync_delay;
        ##2 (state.sync2 == $past(PORT_IN, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("synchroniser depth wrong");

    c_la_flag:     cover property (LOGIC_ARRAY_OUT[2] && state.flag[2]);
    c_int_fires:   cover property (!state.intr ##1 state.intr);
    c_deferred:    cover property (state.pend ##1 state.intr);
    c_lock_reject: cover property (REG_REQ.wr && state.lock_port[0] && is_port);
    c_hw_restore:  cover property (hw_active && CFG_RESTORE_DEFAULTS);
endmodule : gpio_port_core

// file: tb/host_model.sv
// host processor model issuing register reads and writes
`timescale 1ns/1ps
module host_model
    import gpio_port_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic [7:0] REG_RDATA,
    output reg_req_t        REG_REQ
);
    initial REG_REQ = '0;

    // called at a clock edge, returns at a clock edge; idle lines show inverted values
    task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wd,
                          output logic [7:0] rdat);
        REG_REQ <= '{rd: rd, wr: !rd, addr: addr, wdata: wd};
        @(posedge CLK);
        REG_REQ <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wd};
        #1 rdat = REG_RDATA;
        @(posedge CLK);
    endtask : access

    // interrupt service: configuration register first, then a burst over every port
    task automatic service(output logic [7:0] rdat);
        access(1'b1, 8'h26, 8'h00, rdat);
        for (int a = 1; a <= NUM_PORTS; a++)
            access(1'b1, 8'(a), 8'h00, rdat);
    endtask : service
endmodule : host_model

// file: tb/tb_top.sv
// self-checking bench of the port expander core
`timescale 1ns/1ps
module tb_top
    import gpio_port_pkg::*;
;
    localparam int   DB = 8;
    logic            clk, rst_n, hw_n, rd_act, stop, c_rest, c_tmr;
    logic [8:0]      pin, la;
    reg_req_t        req;
    logic [7:0]      rdata, v, r;
    port_cfg_t [8:0] cfg;
    logic            cfg_lock, int_n, ints_n, trn_n, abort, tclr;
    int              error_cnt, num_checks;

    gpio_port_core #(.DEBOUNCE_TICKS(DB)) u_gpio_port_core (
        .CLK(clk), .RESET_N(rst_n), .HW_RESET_N(hw_n), .REG_REQ(req),
        .BUS_READ_ACTIVE(rd_act), .BUS_STOP(stop), .CFG_RESTORE_DEFAULTS(c_rest),
        .CFG_CLEAR_TIMERS(c_tmr), .PORT_IN(pin), .LOGIC_ARRAY_OUT(la),
        .REG_RDATA(rdata), .PORT_CFG(cfg), .CONFIG_LOCK(cfg_lock), .INT_N(int_n),
        .INT_STATUS_N(ints_n), .TRANSITION_N(trn_n), .BUS_ABORT(abort), .TIMER_CLEAR(tclr)
    );
    host_model u_host_model (.CLK(clk), .REG_RDATA(rdata), .REG_REQ(req));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host_model.access(1'b0, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        u_host_model.access(1'b1, a, 8'h00, r);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic pulse_stop;
        rd_act <= 1'b0;
        stop <= 1'b1;
        tick(1);
        stop <= 1'b0;
        tick(3);
    endtask : pulse_stop
    function automatic logic [7:0] in_rd(input logic [7:0] c, input logic f, input logic l);
        return {c[7:2], f, l};
    endfunction : in_rd
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    initial
    begin
        void'($urandom(26502));
        {rst_n, hw_n, rd_act, stop, c_rest, c_tmr} = 6'b01_0000;
        pin = '0;
        la = '0;
        tick(10);
        rst_n <= 1'b1;
        for (int i = 1; i <= 9; i++)
        begin
            rd(8'(i));
            chk("port_por", in_rd(PORT_POR, 1'b0, 1'b0), r);
        end
        rd(LOCK_LOW_ADDR);
        chk("lock_lo_por", 8'h00, r);
        // random output settings on ports 3 and 6..9
        for (int i = 2; i < 9; i++)
        begin
            if (i == 3 || i == 4)
                continue;
            v = 8'($urandom()) & 8'h7f;
            wr(PORT_FIRST_ADDR + 8'(i), v);
            rd(PORT_FIRST_ADDR + 8'(i));
            chk("out_rd", v, r);
            chk("out_cfg", v, cfg[i]);
        end
        pin <= 9'h1e4;
        tick(6);
        chk("out_no_detect", 8'h01, {7'h00, trn_n});
        la[2] <= 1'b1;
        tick(3);
        chk("la_detect", 8'h00, {7'h00, trn_n});
        rd(8'h03);
        chk("la_read_clr", 8'h01, {7'h00, trn_n});
        la[2] <= 1'b0;
        pin <= '0;
        tick(6);
        // lock registers
        wr(LOCK_HIGH_ADDR, 8'h01);
        v = cfg[5];
        wr(8'h06, ~v);
        chk("lock_out", v, cfg[5]);
        wr(LOCK_HIGH_ADDR, 8'h00);
        rd(LOCK_HIGH_ADDR);
        chk("lock_hi", 8'h01, r);
        wr(LOCK_LOW_ADDR, 8'h0a);
        rd(LOCK_LOW_ADDR);
        chk("lock_lo", 8'h0a, r);
        chk("cfg_lock", 8'h01, {7'h00, cfg_lock});
        wr(8'h01, 8'h00);
        pin[0] <= 1'b1;
        tick(5);
        rd(8'h01);
        chk("lock_in", in_rd(PORT_POR, 1'b1, 1'b1), r);
        rd(8'h50);
        chk("unmapped", 8'h00, r);
        // change flag without interrupt enable
        pin[4] <= 1'b1;
        tick(5);
        chk("trn_noirq", 8'h00, {7'h00, trn_n});
        chk("int_noirq", 8'h01, {7'h00, int_n});
        rd(8'h05);
        chk("p5_flag", in_rd(PORT_POR, 1'b1, 1'b1), r);
        // enabled change raises the interrupt, a read releases it
        wr(8'h02, 8'ha0);
        rd(8'h02);
        chk("p2_snap", in_rd(8'ha0, 1'b0, 1'b0), r);
        pin[1] <= 1'b1;
        tick(5);
        chk("int_n", 8'h00, {7'h00, int_n});
        chk("int_st", 8'h00, {7'h00, ints_n});
        chk("trn_n", 8'h00, {7'h00, trn_n});
        rd(8'h02);
        chk("p2_flag", in_rd(8'ha0, 1'b1, 1'b1), r);
        chk("int_rel", 8'h01, {7'h00, int_n});
        chk("trn_clr", 8'h01, {7'h00, trn_n});
        // change during a read sequence: dropped when read, else delivered at stop
        rd_act <= 1'b1;
        pin[1] <= 1'b0;
        tick(5);
        chk("int_defer", 8'h01, {7'h00, int_n});
        rd(8'h02);
        pulse_stop();
        chk("int_drop", 8'h01, {7'h00, int_n});
        rd_act <= 1'b1;
        pin[1] <= 1'b1;
        tick(5);
        chk("int_hold", 8'h01, {7'h00, int_n});
        pulse_stop();
        chk("int_stop", 8'h00, {7'h00, int_n});
        // hardware reset with both options, interrupt pending
        {c_rest, c_tmr, hw_n} <= 3'b110;
        tick(3);
        chk("abort", 8'h01, {7'h00, abort});
        chk("tmr_clr", 8'h01, {7'h00, tclr});
        chk("int_kept", 8'h00, {7'h00, int_n});
        hw_n <= 1'b1;
        tick(4);
        chk("abort_off", 8'h00, {7'h00, abort});
        chk("int_after", 8'h00, {7'h00, int_n});
        chk("cfg_restore", PORT_POR, cfg[5]);
        chk("cfg_lock_clr", 8'h00, {7'h00, cfg_lock});
        rd(LOCK_HIGH_ADDR);
        chk("lock_clr", 8'h00, r);
        u_host_model.service(r);
        chk("int_served", 8'h01, {7'h00, int_n});
        chk("trn_served", 8'h01, {7'h00, trn_n});
        // debounce on port 4
        wr(8'h04, 8'h84);
        rd(8'h04);
        pin[3] <= 1'b1;
        tick(2);
        rd(8'h04);
        chk("db_hold", in_rd(8'h84, 1'b0, 1'b0), r);
        tick(4 * DB);
        rd(8'h04);
        chk("db_new", in_rd(8'h84, 1'b1, 1'b1), r);
        test_done();
    end
endmodule : tb_top
